/* File: hdl/iam_ingress_acl_guard.sv */
// second ingress classifier action merge and source mac / source ip guard table
//
// Contract
// [RULE_01] copy request forwarded if either vector asks hit-once or copy; mirror, learning inhibit ORed.
// [RULE_02] extraction queue in merged vector comes from the second lookup.
// [RULE_03] rewriter command from second lookup unless its low nibble is zero.
// [RULE_04] both lookups copying: merged rule identifier is the sum of both.
// [RULE_05] policer enable, index and table-only come from the first lookup only.
// [RULE_06] mask mode is the stronger; mask is first alone or AND of both.
// [RULE_07] second redirect or first no-action gives second mask; second redirect gives redirect.
// [RULE_08] for multicast mac table hits, policy forwarding acts as permit/deny.
// [RULE_09] table holds 128 ipv6 half-entry guards or 256 ipv4 guards.
// [RULE_10] ipv6 key: type 8 at 0, port at 4, smac at 8, sip at 56.
// [RULE_11] ipv4 key: port at 0, smac at 4, sip at 52.
// [RULE_12] guard action only produced on a match; no default action otherwise.
// [RULE_13] copy bit 0 requests a processor copy to the queue in bits 3:1.
// [RULE_14] forward block bit 4 denies front-port forwarding; processor copies remain.
// [RULE_15] host valid bit 5 is passed on as an input to later keys.
// [RULE_16] hit flag bit 6 is set each time a frame matches the entry.
// [RULE_17] hit flag stays set until software writes the action back with it cleared.
`timescale 1ns/100ps
`include "iam_defines.svh"

module iam_ingress_acl_guard (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // apb slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output      logic [31:0]               prdata,
  output      logic                      pready,
  output      logic                      pslverr,
  // action merge
  input  wire logic                      act_valid,
  input  wire iam_pkg::iam_action_type   first_act,
  input  wire iam_pkg::iam_action_type   second_act,
  input  wire logic                      mc_entry_hit,
  output      logic                      merged_valid,
  output      iam_pkg::iam_action_type   merged_act,
  // source guard lookup
  input  wire logic                      guard_req_valid,
  input  wire iam_pkg::iam_guard_req_type guard_req,
  output      logic                      guard_req_ready,
  output      logic                      guard_done,
  output      logic                      guard_hit,
  output      iam_pkg::iam_guard_act_type guard_act,
  output      logic                      host_valid
);

  typedef struct packed {
    logic                          ctrl_en;
    logic [7:0]                    index;
    logic [`IAM_SLOT_KEY_W-1:0]    stage_key;
    logic                          stage_valid;
    logic                          stage_v6;
    logic [`IAM_ACT_W-1:0]         stage_act;
    logic [`IAM_SLOTS-1:0]         slot_valid;
    iam_pkg::iam_scan_state_type   scan;
    logic [7:0]                    scan_ptr;
    iam_pkg::iam_guard_req_type    req;
    logic                          done;
    logic                          hit;
    iam_pkg::iam_guard_act_type    gact;
    logic [7:0]                    hit_slot;
    logic [31:0]                   hit_count;
  } iam_guard_state_type;

  iam_guard_state_type st_q;
  iam_guard_state_type st_d;

  // table storage: v6 flag, action, key word
  logic [`IAM_SLOT_W-1:0] slot_mem [`IAM_SLOTS];

  logic                   mem_we;
  logic [7:0]             mem_waddr;
  logic [`IAM_SLOT_W-1:0] mem_wdata;
  logic                   sticky_we;
  logic [7:0]             sticky_addr;
  logic [`IAM_SLOT_W-1:0] cur_slot;
  logic [`IAM_SLOT_W-1:0] ev_slot;
  logic [`IAM_SLOT_W-1:0] od_slot;
  logic [`IAM_SLOT_W-1:0] idx_slot;
  logic [7:0]             ev_addr;
  logic [7:0]             od_addr;
  logic                   apb_wr;
  logic                   addr_ok;

  function automatic logic [`IAM_V6_KEY_W-1:0] key_v6(input iam_pkg::iam_guard_req_type r);
    key_v6 = {r.source_ip_field, r.source_mac_field, r.ingress_port_no, `IAM_HALF_TYPE}; // [RULE_10]
  endfunction

  function automatic logic [`IAM_V4_KEY_W-1:0] key_v4(input iam_pkg::iam_guard_req_type r);
    key_v4 = {r.source_ip_field[31:0], r.source_mac_field, r.ingress_port_no}; // [RULE_11]
  endfunction

  iam_action_merge u_merge (
    .clk          (clk),
    .rst_n        (rst_n),
    .in_valid     (act_valid),
    .first_act    (first_act),
    .second_act   (second_act),
    .mc_entry_hit (mc_entry_hit),
    .out_valid    (merged_valid),
    .merged_act   (merged_act)
  );

  // address decode
  always_comb begin
    case (paddr)
      `IAM_REG_CTRL, `IAM_REG_INDEX, `IAM_REG_KEY0, `IAM_REG_KEY1, `IAM_REG_KEY2,
      `IAM_REG_ENTRY, `IAM_REG_CMD, `IAM_REG_STATUS, `IAM_REG_HITS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign apb_wr  = psel & penable & pwrite & addr_ok;

  // read mux
  always_comb begin
    case (paddr)
      `IAM_REG_CTRL:   prdata = {31'h0000_0000, st_q.ctrl_en};
      `IAM_REG_INDEX:  prdata = {24'h00_0000, st_q.index};
      `IAM_REG_KEY0:   prdata = st_q.stage_key[31:0];
      `IAM_REG_KEY1:   prdata = st_q.stage_key[63:32];
      `IAM_REG_KEY2:   prdata = st_q.stage_key[95:64];
      `IAM_REG_ENTRY:  prdata = {22'h00_0000, st_q.stage_v6, st_q.stage_valid, 1'b0, st_q.stage_act};
      `IAM_REG_STATUS: prdata = {22'h00_0000, st_q.hit, (st_q.scan == iam_pkg::IAM_SCAN), st_q.hit_slot};
      `IAM_REG_HITS:   prdata = st_q.hit_count;
      default:         prdata = 32'h0000_0000;
    endcase
  end

  // table reads
  always_comb begin
    ev_addr  = {st_q.scan_ptr[7:1], 1'b0};
    od_addr  = {st_q.scan_ptr[7:1], 1'b1};
    cur_slot = slot_mem[st_q.scan_ptr];
    ev_slot  = slot_mem[ev_addr];
    od_slot  = slot_mem[od_addr];
    idx_slot = slot_mem[st_q.index];
  end

  always_comb begin
    logic                  match;
    logic                  last;
    logic [7:0]            base;
    logic [`IAM_ACT_W-1:0] act;
    st_d      = st_q;
    st_d.done = 1'b0;
    mem_we    = 1'b0;
    mem_waddr = st_q.index;
    mem_wdata = {st_q.stage_v6, st_q.stage_act, st_q.stage_key};
    sticky_we = 1'b0;
    match     = 1'b0;
    last      = 1'b0;
    base      = st_q.scan_ptr;
    act       = cur_slot[`IAM_SLOT_ACT_MSB:`IAM_SLOT_ACT_LSB];
    sticky_addr = base;
    // register writes
    if (apb_wr) begin
      case (paddr)
        `IAM_REG_CTRL:  st_d.ctrl_en = pwdata[0];
        `IAM_REG_INDEX: st_d.index = pwdata[7:0];
        `IAM_REG_KEY0:  st_d.stage_key[31:0] = pwdata;
        `IAM_REG_KEY1:  st_d.stage_key[63:32] = pwdata;
        `IAM_REG_KEY2:  st_d.stage_key[95:64] = pwdata;
        `IAM_REG_ENTRY: begin
          st_d.stage_act   = pwdata[`IAM_ACT_W-1:0];
          st_d.stage_valid = pwdata[`IAM_ENTRY_VALID_BIT];
          st_d.stage_v6    = pwdata[`IAM_ENTRY_V6_BIT];
        end
        `IAM_REG_CMD: begin
          if (pwdata[`IAM_CMD_WRITE_BIT]) begin
            mem_we = 1'b1; // [RULE_17]
            st_d.slot_valid[st_q.index] = st_q.stage_valid;
          end else if (pwdata[`IAM_CMD_READ_BIT]) begin
            st_d.stage_key   = idx_slot[`IAM_SLOT_KEY_W-1:0];
            st_d.stage_act   = idx_slot[`IAM_SLOT_ACT_MSB:`IAM_SLOT_ACT_LSB];
            st_d.stage_v6    = idx_slot[`IAM_SLOT_V6_BIT];
            st_d.stage_valid = st_q.slot_valid[st_q.index];
          end
        end
        default: st_d.ctrl_en = st_q.ctrl_en;
      endcase
    end
    // guard lookup scan
    case (st_q.scan)
      iam_pkg::IAM_IDLE: begin
        if (guard_req_valid) begin
          st_d.req      = guard_req;
          st_d.scan_ptr = 8'h00;
          if (st_q.ctrl_en) begin
            st_d.scan = iam_pkg::IAM_SCAN;
          end else begin
            st_d.done = 1'b1;
            st_d.hit  = 1'b0;
            st_d.gact = '0; // [RULE_12]
          end
        end
      end
      iam_pkg::IAM_SCAN: begin
        if (st_q.req.is_v6) begin
          base  = ev_addr;
          act   = ev_slot[`IAM_SLOT_ACT_MSB:`IAM_SLOT_ACT_LSB];
          last  = (st_q.scan_ptr == `IAM_LAST_V6_SLOT);
          match = st_q.slot_valid[ev_addr] & st_q.slot_valid[od_addr] & ev_slot[`IAM_SLOT_V6_BIT]
                  & od_slot[`IAM_SLOT_V6_BIT]
                  & ({od_slot[`IAM_ODD_KEY_W-1:0], ev_slot[`IAM_SLOT_KEY_W-1:0]} == key_v6(st_q.req)); // [RULE_09]
        end else begin
          last  = (st_q.scan_ptr == `IAM_LAST_V4_SLOT);
          match = st_q.slot_valid[st_q.scan_ptr] & ~cur_slot[`IAM_SLOT_V6_BIT]
                  & (cur_slot[`IAM_V4_KEY_W-1:0] == key_v4(st_q.req)); // [RULE_09]
        end
        sticky_addr = base;
        if (match) begin
          sticky_we      = 1'b1; // [RULE_16]
          st_d.done      = 1'b1;
          st_d.hit       = 1'b1;
          st_d.gact      = act; // [RULE_13] [RULE_14] [RULE_15]
          st_d.gact.entry_hit_flag = 1'b1;
          st_d.hit_slot  = base;
          st_d.hit_count = st_q.hit_count + 32'h0000_0001;
          st_d.scan      = iam_pkg::IAM_IDLE;
        end else if (last) begin
          st_d.done = 1'b1;
          st_d.hit  = 1'b0;
          st_d.gact = '0; // [RULE_12]
          st_d.scan = iam_pkg::IAM_IDLE;
        end else begin
          st_d.scan_ptr = st_q.scan_ptr + (st_q.req.is_v6 ? `IAM_V6_STEP : `IAM_V4_STEP);
        end
      end
      default: st_d.scan = iam_pkg::IAM_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q         <= '0;
      st_q.ctrl_en <= `IAM_CTRL_RESET;
      st_q.scan    <= iam_pkg::IAM_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // table write port; a hit on the slot being rewritten keeps its flag set
  always_ff @(posedge clk) begin
    if (mem_we) begin
      slot_mem[mem_waddr] <= mem_wdata
                             | ({`IAM_SLOT_W{sticky_we && sticky_addr == mem_waddr}}
                                & (`IAM_SLOT_W'(1) << (`IAM_SLOT_ACT_LSB + `IAM_ACT_STICKY_BIT))); // [RULE_17]
    end
    if (sticky_we && !(mem_we && sticky_addr == mem_waddr)) begin
      slot_mem[sticky_addr][`IAM_SLOT_ACT_LSB + `IAM_ACT_STICKY_BIT] <= 1'b1; // [RULE_16]
    end
  end

  assign guard_req_ready = (st_q.scan == iam_pkg::IAM_IDLE);
  assign guard_done      = st_q.done;
  assign guard_hit       = st_q.hit;
  assign guard_act       = st_q.gact;
  assign host_valid      = st_q.gact.host_valid; // [RULE_15]

endmodule

/* File: hdl/iam_defines.svh */
// constants of the ingress acl action merge and source guard block
`ifndef IAM_DEFINES_SVH
`define IAM_DEFINES_SVH

// source guard table
`define IAM_SLOTS          256
`define IAM_V6_ENTRIES     128
`define IAM_SLOT_KEY_W     96
`define IAM_SLOT_W         104
`define IAM_SLOT_V6_BIT    103
`define IAM_SLOT_ACT_MSB   102
`define IAM_SLOT_ACT_LSB   96
`define IAM_V6_KEY_W       184
`define IAM_V4_KEY_W       84
`define IAM_ODD_KEY_W      88
`define IAM_HALF_TYPE      4'h8
`define IAM_LAST_V4_SLOT   8'hFF
`define IAM_LAST_V6_SLOT   8'hFE
`define IAM_V4_STEP        8'h01
`define IAM_V6_STEP        8'h02

// key field positions
`define IAM_V6_TYPE_LSB    0
`define IAM_V6_PORT_LSB    4
`define IAM_V6_SMAC_LSB    8
`define IAM_V6_SIP_LSB     56
`define IAM_V4_PORT_LSB    0
`define IAM_V4_SMAC_LSB    4
`define IAM_V4_SIP_LSB     52

// source guard action bits
`define IAM_ACT_W          7
`define IAM_ACT_COPY_BIT   0
`define IAM_ACT_QUEUE_LSB  1
`define IAM_ACT_BLOCK_BIT  4
`define IAM_ACT_HOST_BIT   5
`define IAM_ACT_STICKY_BIT 6

// merge constants
`define IAM_REW_NOP        4'h0
`define IAM_PORT_MASK_W    11
`define IAM_POLICER_IDX_W  8

// register map
`define IAM_REG_CTRL       8'h00
`define IAM_REG_INDEX      8'h04
`define IAM_REG_KEY0       8'h08
`define IAM_REG_KEY1       8'h0C
`define IAM_REG_KEY2       8'h10
`define IAM_REG_ENTRY      8'h14
`define IAM_REG_CMD        8'h18
`define IAM_REG_STATUS     8'h1C
`define IAM_REG_HITS       8'h20
`define IAM_ENTRY_VALID_BIT 8
`define IAM_ENTRY_V6_BIT   9
`define IAM_CMD_WRITE_BIT  0
`define IAM_CMD_READ_BIT   1
`define IAM_CTRL_RESET     1'h0

`endif

/* File: hdl/iam_pkg.sv */
// types of the ingress acl action merge and source guard block
package iam_pkg;

  typedef enum logic [1:0] {
    IAM_MASK_NONE,
    IAM_MASK_PERMIT,
    IAM_MASK_POLICY,
    IAM_MASK_REDIRECT
  } iam_mask_mode_type;

  typedef struct packed {
    logic              copy_first_hit_only;
    logic              copy_to_processor;
    logic [2:0]        extraction_queue_sel;
    logic              mirror_request;
    logic              learning_inhibit;
    logic [8:0]        rewriter_command;
    logic [5:0]        rule_identifier;
    logic              policer_on;
    logic [7:0]        policer_index;
    logic              policer_table_only;
    iam_mask_mode_type mask_mode;
    logic [10:0]       port_mask;
  } iam_action_type;

  typedef struct packed {
    logic         is_v6;
    logic [3:0]   ingress_port_no;
    logic [47:0]  source_mac_field;
    logic [127:0] source_ip_field;
  } iam_guard_req_type;

  typedef struct packed {
    logic       entry_hit_flag;
    logic       host_valid;
    logic       forward_block;
    logic [2:0] extraction_queue_sel;
    logic       copy_to_processor;
  } iam_guard_act_type;

  typedef enum logic {
    IAM_IDLE,
    IAM_SCAN
  } iam_scan_state_type;

endpackage

/* File: hdl/iam_action_merge.sv */
// merges the two second-stage classifier action vectors into one
`timescale 1ns/100ps
`include "iam_defines.svh"

module iam_action_merge (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // lookup results
  input  wire logic               in_valid,
  input  wire iam_pkg::iam_action_type first_act,
  input  wire iam_pkg::iam_action_type second_act,
  input  wire logic               mc_entry_hit,
  // merged result
  output      logic               out_valid,
  output      iam_pkg::iam_action_type merged_act
);

  typedef struct packed {
    logic                    valid;
    iam_pkg::iam_action_type act;
  } iam_merge_state_type;

  iam_merge_state_type st_q;
  iam_merge_state_type st_d;

  // policy forwarding is demoted for multicast entries
  function automatic iam_pkg::iam_mask_mode_type eff_mode(input iam_pkg::iam_mask_mode_type m,
                                                          input logic mc);
    eff_mode = (mc && m == iam_pkg::IAM_MASK_POLICY) ? iam_pkg::IAM_MASK_PERMIT : m; // [RULE_08]
  endfunction

  always_comb begin
    iam_pkg::iam_mask_mode_type m1;
    iam_pkg::iam_mask_mode_type m2;
    iam_pkg::iam_action_type    a;
    logic                       f_cpu;
    logic                       s_cpu;
    m1 = eff_mode(first_act.mask_mode, mc_entry_hit);
    m2 = eff_mode(second_act.mask_mode, mc_entry_hit);
    f_cpu = first_act.copy_first_hit_only | first_act.copy_to_processor;
    s_cpu = second_act.copy_first_hit_only | second_act.copy_to_processor;
    a = first_act;
    a.copy_first_hit_only = first_act.copy_first_hit_only | second_act.copy_first_hit_only;
    a.copy_to_processor   = f_cpu | s_cpu; // [RULE_01]
    a.mirror_request      = first_act.mirror_request | second_act.mirror_request; // [RULE_01]
    a.learning_inhibit    = first_act.learning_inhibit | second_act.learning_inhibit; // [RULE_01]
    a.extraction_queue_sel = second_act.extraction_queue_sel; // [RULE_02]
    if (second_act.rewriter_command[3:0] == `IAM_REW_NOP) begin
      a.rewriter_command = first_act.rewriter_command; // [RULE_03]
    end else begin
      a.rewriter_command = second_act.rewriter_command; // [RULE_03]
    end
    if (first_act.copy_to_processor && second_act.copy_to_processor) begin
      a.rule_identifier = 6'(first_act.rule_identifier + second_act.rule_identifier); // [RULE_04]
    end else if (f_cpu) begin
      a.rule_identifier = first_act.rule_identifier;
    end else begin
      a.rule_identifier = second_act.rule_identifier;
    end
    a.policer_on         = first_act.policer_on; // [RULE_05]
    a.policer_index      = first_act.policer_index; // [RULE_05]
    a.policer_table_only = first_act.policer_table_only; // [RULE_05]
    if (m2 == iam_pkg::IAM_MASK_REDIRECT) begin
      a.mask_mode = iam_pkg::IAM_MASK_REDIRECT; // [RULE_07]
    end else if (m1 > m2) begin
      a.mask_mode = m1; // [RULE_06]
    end else begin
      a.mask_mode = m2; // [RULE_06]
    end
    if (m2 == iam_pkg::IAM_MASK_REDIRECT || m1 == iam_pkg::IAM_MASK_NONE) begin
      a.port_mask = second_act.port_mask; // [RULE_07]
    end else if (m2 == iam_pkg::IAM_MASK_NONE) begin
      a.port_mask = first_act.port_mask; // [RULE_06]
    end else begin
      a.port_mask = first_act.port_mask & second_act.port_mask; // [RULE_06]
    end
    st_d = st_q;
    st_d.valid = in_valid;
    if (in_valid) begin
      st_d.act = a;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign out_valid  = st_q.valid;
  assign merged_act = st_q.act;

endmodule

/* File: testbench/iam_guard_asserts.sv */
// port assertions of the acl action merge and source guard block
`timescale 1ns/100ps
module iam_guard_asserts (
  // clock and reset
  input wire logic                       clk,
  input wire logic                       rst_n,
  // action merge
  input wire logic                       act_valid,
  input wire iam_pkg::iam_action_type    first_act,
  input wire iam_pkg::iam_action_type    second_act,
  input wire logic                       mc_entry_hit,
  input wire logic                       merged_valid,
  input wire iam_pkg::iam_action_type    merged_act,
  // source guard
  input wire logic                       guard_req_valid,
  input wire logic                       guard_req_ready,
  input wire logic                       guard_done,
  input wire logic                       guard_hit,
  input wire iam_pkg::iam_guard_act_type guard_act,
  input wire logic                       host_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_copy_or: assert property (act_valid |=> merged_valid && merged_act.copy_to_processor ==
    $past(|{first_act.copy_to_processor, first_act.copy_first_hit_only,
    second_act.copy_to_processor, second_act.copy_first_hit_only})) else $error("copy request not merged");
  a_mirror_or: assert property (act_valid |=> {merged_act.mirror_request, merged_act.learning_inhibit} ==
    $past({first_act.mirror_request, first_act.learning_inhibit} | {second_act.mirror_request,
    second_act.learning_inhibit})) else $error("mirror or learning not merged");
  a_queue_second: assert property (act_valid |=>
    merged_act.extraction_queue_sel == $past(second_act.extraction_queue_sel)) else $error("queue not from second");
  a_rew_select: assert property (act_valid |=> merged_act.rewriter_command ==
    ($past(second_act.rewriter_command[3:0]) == 4'h0 ? $past(first_act.rewriter_command) :
    $past(second_act.rewriter_command))) else $error("rewriter command wrong");
  a_id_sum: assert property (act_valid && first_act.copy_to_processor && second_act.copy_to_processor |=>
    merged_act.rule_identifier == $past(first_act.rule_identifier + second_act.rule_identifier))
    else $error("rule identifier not summed");
  a_policer_first: assert property (act_valid |=> {merged_act.policer_on, merged_act.policer_index,
    merged_act.policer_table_only} == $past({first_act.policer_on, first_act.policer_index,
    first_act.policer_table_only})) else $error("policer not from first");
  a_redirect_wins: assert property (act_valid && second_act.mask_mode == iam_pkg::IAM_MASK_REDIRECT |=>
    merged_act.mask_mode == iam_pkg::IAM_MASK_REDIRECT && merged_act.port_mask == $past(second_act.port_mask))
    else $error("second redirect lost");
  a_scan_bound: assert property (guard_req_valid && guard_req_ready |-> ##[1:258] guard_done)
    else $error("lookup did not end");
  a_miss_zero: assert property (guard_done && !guard_hit |-> guard_act == 7'h00)
    else $error("action on miss");
  a_host_out: assert property (guard_done |-> host_valid == guard_act.host_valid)
    else $error("host flag differs");
  a_entry_hit_flag: assert property (guard_done && guard_hit |-> guard_act.entry_hit_flag)
    else $error("hit flag not set");

  c_mc_policy: cover property (act_valid && mc_entry_hit && second_act.mask_mode == iam_pkg::IAM_MASK_POLICY);
  c_guard_hit: cover property (guard_done && guard_hit);
  c_guard_miss: cover property (guard_done && !guard_hit);
endmodule

bind iam_ingress_acl_guard iam_guard_asserts chk_u (.clk, .rst_n, .act_valid, .first_act, .second_act,
  .mc_entry_hit, .merged_valid, .merged_act, .guard_req_valid, .guard_req_ready, .guard_done, .guard_hit,
  .guard_act, .host_valid);

/* File: testbench/iam_cls_model.sv */
// classifier match side: random lookup result pairs for the merge
`timescale 1ns/100ps
module iam_cls_model (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // control
  input  wire logic               run,
  // lookup results
  output logic                    act_valid,
  output iam_pkg::iam_action_type first_act,
  output iam_pkg::iam_action_type second_act,
  output logic                    mc_entry_hit
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_valid <= 1'b0;
      first_act <= '0;
      second_act <= '0;
      mc_entry_hit <= 1'b0;
    end else begin
      act_valid <= run & 1'($urandom);
      first_act <= iam_pkg::iam_action_type'(45'({$urandom, $urandom}));
      second_act <= iam_pkg::iam_action_type'(45'({$urandom, $urandom}));
      mc_entry_hit <= 1'($urandom);
    end
  end
endmodule

/* File: testbench/iam_ingress_acl_guard_tb.sv */
// self-checking bench of the acl action merge and source guard block
`timescale 1ns/100ps
`include "iam_defines.svh"
module iam_ingress_acl_guard_tb;
  logic                       clk, rst_n, psel, penable, pwrite, pready, pslverr, err, run;
  logic [7:0]                 paddr;
  logic [31:0]                pwdata, prdata, rd;
  logic                       act_valid, mc_entry_hit, merged_valid;
  iam_pkg::iam_action_type    first_act, second_act, merged_act;
  logic                       guard_req_valid, guard_req_ready, guard_done, guard_hit, host_valid;
  iam_pkg::iam_guard_req_type guard_req;
  iam_pkg::iam_guard_act_type guard_act;
  iam_pkg::iam_action_type    exp_q[$];
  logic [47:0]                mac;
  logic [127:0]               ip;
  logic [183:0]               k6;
  int                         fails, tests_run, cyc, lat;

  iam_ingress_acl_guard dut_u (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .act_valid, .first_act, .second_act, .mc_entry_hit, .merged_valid, .merged_act,
    .guard_req_valid, .guard_req, .guard_req_ready, .guard_done, .guard_hit, .guard_act, .host_valid);
  iam_cls_model cls_u (.clk, .rst_n, .run, .act_valid, .first_act, .second_act, .mc_entry_hit);

  always #4 clk = ~clk;

  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask

  // expected merged vector
  function automatic iam_pkg::iam_action_type merge(input iam_pkg::iam_action_type f, s, input logic mc);
    iam_pkg::iam_action_type r;
    int fm;
    int sm;
    r = f;
    fm = int'(f.mask_mode);
    sm = int'(s.mask_mode);
    if (mc && fm == 2) fm = 1;
    if (mc && sm == 2) sm = 1;
    r.copy_first_hit_only = f.copy_first_hit_only | s.copy_first_hit_only;
    r.copy_to_processor = |{f.copy_first_hit_only, f.copy_to_processor, s.copy_first_hit_only, s.copy_to_processor};
    r.extraction_queue_sel = s.extraction_queue_sel;
    r.mirror_request = f.mirror_request | s.mirror_request;
    r.learning_inhibit = f.learning_inhibit | s.learning_inhibit;
    if (s.rewriter_command[3:0] != 4'h0) r.rewriter_command = s.rewriter_command;
    if (f.copy_to_processor && s.copy_to_processor) r.rule_identifier = f.rule_identifier + s.rule_identifier;
    else if (!(f.copy_to_processor | f.copy_first_hit_only)) r.rule_identifier = s.rule_identifier;
    r.mask_mode = iam_pkg::iam_mask_mode_type'(2'(fm > sm ? fm : sm));
    if (sm == 3 || fm == 0) r.port_mask = s.port_mask;
    else if (sm != 0) r.port_mask = f.port_mask & s.port_mask;
    return r;
  endfunction

  always @(posedge clk) begin
    if (merged_valid === 1'b1) chk(merged_act, exp_q.pop_front(), "merged vector");
    if (act_valid === 1'b1) exp_q.push_back(merge(first_act, second_act, mc_entry_hit));
    cyc++;
    if (cyc == 5000) begin
      fails++;
      results();
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic prog(input logic [7:0] slot, input logic [95:0] k, input logic [31:0] e);
    apb(1'b1, `IAM_REG_INDEX, {24'h000000, slot});
    apb(1'b1, `IAM_REG_KEY0, k[31:0]);
    apb(1'b1, `IAM_REG_KEY1, k[63:32]);
    apb(1'b1, `IAM_REG_KEY2, k[95:64]);
    apb(1'b1, `IAM_REG_ENTRY, e);
    apb(1'b1, `IAM_REG_CMD, 32'h00000001);
  endtask

  task automatic look(input logic v6, input logic [3:0] p, input logic [127:0] a, input int elat,
                      input logic [6:0] eact);
    @(posedge clk);
    guard_req_valid <= 1'b1;
    guard_req <= {v6, p, mac, a};
    @(posedge clk);
    while (guard_req_ready !== 1'b1) @(posedge clk);
    guard_req_valid <= 1'b0;
    lat = 1;
    #1;
    while (guard_done !== 1'b1 && lat < 400) begin
      @(posedge clk);
      #1;
      lat++;
    end
    chk(lat, elat, "lookup latency");
    chk({guard_hit, host_valid, guard_act}, {eact != 7'h00, eact[5], eact}, "guard result");
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {psel, penable, pwrite, run, guard_req_valid} = '0;
    paddr = '0;
    pwdata = '0;
    guard_req = '0;
    {fails, tests_run, cyc} = '0;
    void'($urandom(32'h1CB0F89F));
    mac = 48'({$urandom, $urandom});
    ip = {$urandom, $urandom, $urandom, $urandom};
    k6 = {ip, mac, 4'h5, `IAM_HALF_TYPE};
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, `IAM_REG_HITS, 32'h0);
    chk({err, rd}, 33'h0, "hit count at reset");
    apb(1'b1, 8'h40, 32'hFFFFFFFF);
    apb(1'b0, 8'h40, 32'h0);
    chk({err, rd}, {1'b1, 32'h0}, "unmapped read");
    look(1'b0, 4'hB, {96'h0, ip[31:0]}, 1, 7'h00);
    apb(1'b1, `IAM_REG_CTRL, 32'h00000001);
    prog(8'h03, {12'h000, ip[31:0], mac, 4'hB}, 32'h0000012B);
    prog(8'hFF, {12'h000, ip[31:0], mac, 4'h2}, 32'h00000110);
    prog(8'h04, k6[95:0], 32'h00000330);
    prog(8'h05, {8'h00, k6[183:96]}, 32'h00000300);
    look(1'b0, 4'hB, {96'h0, ip[31:0]}, 5, 7'h6B);
    look(1'b0, 4'h2, {96'h0, ip[31:0]}, 257, 7'h50);
    look(1'b0, 4'h7, {96'h0, ip[31:0]}, 257, 7'h00);
    look(1'b1, 4'h5, ip, 4, 7'h70);
    look(1'b1, 4'h6, ip, 129, 7'h00);
    apb(1'b1, `IAM_REG_INDEX, 32'h00000003);
    apb(1'b1, `IAM_REG_CMD, 32'h00000002);
    apb(1'b0, `IAM_REG_ENTRY, 32'h0);
    chk(rd[9:0], 10'h16B, "hit flag kept");
    apb(1'b1, `IAM_REG_ENTRY, 32'h0000012B);
    apb(1'b1, `IAM_REG_CMD, 32'h00000001);
    apb(1'b1, `IAM_REG_CMD, 32'h00000002);
    apb(1'b0, `IAM_REG_ENTRY, 32'h0);
    chk(rd[9:0], 10'h12B, "hit flag cleared");
    apb(1'b0, `IAM_REG_HITS, 32'h0);
    chk(rd, 32'h00000003, "hit count");
    run <= 1'b1;
    repeat (600) @(posedge clk);
    run <= 1'b0;
    repeat (4) @(posedge clk);
    chk(exp_q.size(), 0, "merged results missing");
    results();
  end
endmodule
